// file: pkg/tpgc_defines.vh
// Purpose: Constants of the three-phase gate control logic
// Assumes: 125 MHz system clock
// Notes: Timing counts are derived from times in their own unit
`ifndef TPGC_DEFINES_VH
`define TPGC_DEFINES_VH

// ==========================================================
// Clock and timing
`define TPGC_CLK_PERIOD_NS 8
`define TPGC_RST_LIMIT_NS 77
`define TPGC_RST_LIMIT_CYC (`TPGC_RST_LIMIT_NS / `TPGC_CLK_PERIOD_NS)
`define TPGC_DT_STEP_NS 50
`define TPGC_DT_STEP_CYC ((`TPGC_DT_STEP_NS + `TPGC_CLK_PERIOD_NS - 1) / `TPGC_CLK_PERIOD_NS)
`define TPGC_DT_MAX_NS 12000
`define TPGC_DT_MAX_STEPS 8'hf0
`define TPGC_DT_RESET 8'h14

// ==========================================================
// Serial frame layout
`define TPGC_FRAME_BITS 5'h10
`define TPGC_OP_MSB 15
`define TPGC_OP_LSB 12
`define TPGC_DATA_MSB 7
`define TPGC_DATA_LSB 0

// ==========================================================
// Serial commands
`define TPGC_OP_NOP 4'h0
`define TPGC_OP_DEADTIME 4'h1
`define TPGC_OP_FILT_LOW 4'h2
`define TPGC_OP_FILT_HIGH 4'h3
`define TPGC_OP_CLR_IRQ 4'h4
`define TPGC_OP_MODE 4'h5

// ==========================================================
// Reset values
`define TPGC_FILT_RESET 4'hf
`define TPGC_SYNC_WIDTH 25
`define TPGC_SYNC_RESET 25'h00000e2

// ==========================================================
// Synchroniser bit positions
`define TPGC_S_SCLK 0
`define TPGC_S_CS 1
`define TPGC_S_SI 2
`define TPGC_S_EN1 3
`define TPGC_S_EN2 4
`define TPGC_S_HS 5
`define TPGC_S_LS 8
`define TPGC_S_CHIPRST 11
`define TPGC_S_PWRGOOD 12
`define TPGC_S_CMP 13
`define TPGC_S_OC 16
`define TPGC_S_FAULT 17

`endif

// file: src/tpgc_gate_ctrl.v
// Purpose: Gate control logic of a three-phase bridge pre-driver
// Assumes: All pins asynchronous to clk_sys; serial clock well below clk_sys / 8
// Notes: Gate outputs are flip-flops gated asynchronously by both enable pins
// Notes on behaviour
// - Gate drives turn on only while both enables are high, else all off.
// - With enables low, logic and serial port keep running normally.
// - Enable gating acts asynchronously, without waiting for a clock edge.
// - After enable recovery, high side needs a low-side pulse first.
// - Chip reset low gives low power, outputs off, weak gate pull-down.
// - Internal logic is reset within 77 ns of chip reset falling.
// - Until supply is good: logic reset, drivers tri-stated, serial port off.
// - Logic supply regulator is off while chip reset is held low.
// - High-side command inputs are active low, idle high.
// - Low-side command inputs are active high, idle low.
// - Fault sets interrupt high, held until the clear command arrives.
// - Two filter registers choose which faults may raise the interrupt.
// - Chip select low frames a command; traffic ignored while it is high.
// - Serial input sampled on falling serial clock, most significant first.
// - Serial output driven only while chip select is low.
// - Serial output changes on rising serial clock edges.
// - Phase level low when its source is below half battery voltage.
// - Overcurrent flag high during overcurrent, low otherwise.
// - Deadtime blanking by default; a mode option overrides it.
// - Leading edge turns partner off now, selected driver after deadtime.
// - Deadtime programmable in 50 ns steps from zero to 12 us; the logic counts 7 cycles (56 ns) per step, up to 240 steps or 13.44 us.
`timescale 1ns/1ps
`default_nettype none
`include "tpgc_defines.vh"

module tpgc_gate_ctrl (
  input wire clk_sys,
  input wire reset_n,
  input wire clkEn,
  input wire chipReset_n,
  input wire powerGood,
  input wire driveEnableFirst,
  input wire driveEnableSecond,
  input wire highCmdA_n,
  input wire highCmdB_n,
  input wire highCmdC_n,
  input wire lowCmdA,
  input wire lowCmdB,
  input wire lowCmdC,
  input wire serialClk,
  input wire chipSelect_n,
  input wire serialIn,
  input wire phaseACmp,
  input wire phaseBCmp,
  input wire phaseCCmp,
  input wire overcurrentCmp,
  input wire [7:0] faultSource,
  output wire highGateA,
  output wire highGateB,
  output wire highGateC,
  output wire lowGateA,
  output wire lowGateB,
  output wire lowGateC,
  output reg gatePullDown_r,
  output reg driverTristate_r,
  output reg regulatorEn_r,
  output reg faultIrq_r,
  output reg serialOut_r,
  output reg serialOutEn_r,
  output reg phaseALevel_r,
  output reg phaseBLevel_r,
  output reg phaseCLevel_r,
  output reg overcurrentFlag_r
);

  localparam TGT_NONE = 2'b00;
  localparam TGT_HIGH = 2'b01;
  localparam TGT_LOW = 2'b10;

  // ==========================================================
  // Input synchronisers
  wire [`TPGC_SYNC_WIDTH-1:0] rawIn;
  reg [`TPGC_SYNC_WIDTH-1:0] syncA_r;
  reg [`TPGC_SYNC_WIDTH-1:0] syncB_r;
  // Third stage keeps each synced bit's previous value for edge detection
  reg [`TPGC_SYNC_WIDTH-1:0] syncPrev_r;

  // Highest bit first, matching the synchroniser bit map
  assign rawIn = {
    faultSource,
    overcurrentCmp,
    phaseCCmp,
    phaseBCmp,
    phaseACmp,
    powerGood,
    chipReset_n,
    lowCmdC,
    lowCmdB,
    lowCmdA,
    highCmdC_n,
    highCmdB_n,
    highCmdA_n,
    driveEnableSecond,
    driveEnableFirst,
    serialIn,
    chipSelect_n,
    serialClk
  };

  // Reset value keeps high commands and chip select idle high, low commands idle low
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      syncA_r <= `TPGC_SYNC_RESET;
      syncB_r <= `TPGC_SYNC_RESET;
      syncPrev_r <= `TPGC_SYNC_RESET;
    end else if (clkEn) begin
      syncA_r <= rawIn;
      syncB_r <= syncA_r;
      syncPrev_r <= syncB_r;
    end
  end

  wire sclkS = syncB_r[`TPGC_S_SCLK];
  wire csS_n = syncB_r[`TPGC_S_CS];
  wire siS = syncB_r[`TPGC_S_SI];
  wire enBothS = syncB_r[`TPGC_S_EN1] & syncB_r[`TPGC_S_EN2];
  wire [2:0] hiReq = ~syncB_r[`TPGC_S_HS +: 3];
  wire [2:0] loReq = syncB_r[`TPGC_S_LS +: 3];
  wire [2:0] hiReqPrev = ~syncPrev_r[`TPGC_S_HS +: 3];
  wire [2:0] loReqPrev = syncPrev_r[`TPGC_S_LS +: 3];
  wire [2:0] hiRise = hiReq & ~hiReqPrev;
  wire [2:0] loRise = loReq & ~loReqPrev;
  wire chipRstS_n = syncB_r[`TPGC_S_CHIPRST];
  wire pwrGoodS = syncB_r[`TPGC_S_PWRGOOD];
  wire [7:0] faultS = syncB_r[`TPGC_S_FAULT +: 8];
  wire [2:0] cmpS = syncB_r[`TPGC_S_CMP +: 3];
  wire ocS = syncB_r[`TPGC_S_OC];

  wire sclkFall = ~sclkS & syncPrev_r[`TPGC_S_SCLK];
  wire sclkRise = sclkS & ~syncPrev_r[`TPGC_S_SCLK];
  wire csFall = ~csS_n & syncPrev_r[`TPGC_S_CS];
  wire csRise = csS_n & ~syncPrev_r[`TPGC_S_CS];

  // Internal reset from chip reset pin or supply monitor
  wire intRst = ~chipRstS_n | ~pwrGoodS;
  wire coreClr = ~reset_n | (clkEn & intRst);

  // ==========================================================
  // Functions
  // Clamped step count keeps the product below 2048
  function [10:0] dtCycles;
    input [7:0] steps;
    reg [31:0] prod;
    begin
      prod = steps * `TPGC_DT_STEP_CYC;
      dtCycles = prod[10:0];
    end
  endfunction

  // ==========================================================
  // Configuration, serial port and fault latches
  reg [7:0] deadtime_r;
  reg [3:0] irqFilterLow_r;
  reg [3:0] irqFilterHigh_r;
  reg simulMode_r;
  reg modeLocked_r;
  reg [7:0] faultLatch_r;
  reg [15:0] rxShift_r;
  reg [15:0] txShift_r;
  reg [4:0] bitCnt_r;
  reg [2:0] hiDrv_r;
  reg [2:0] loDrv_r;
  reg [2:0] prechg_r;
  reg [5:0] tgt_r;
  reg [32:0] tmr_r;

  // ==========================================================
  // Frame decode and fault next state
  wire [3:0] opcode = rxShift_r[`TPGC_OP_MSB:`TPGC_OP_LSB];
  wire [7:0] opData = rxShift_r[`TPGC_DATA_MSB:`TPGC_DATA_LSB];
  // Only a frame of exactly 16 bits is executed, at chip select rise
  wire frameDone = csRise & (bitCnt_r == `TPGC_FRAME_BITS);
  wire clrCmd = frameDone & (opcode == `TPGC_OP_CLR_IRQ);
  // Read word captured at frame start so it cannot change mid-shift
  wire [15:0] statusWord = {
    faultLatch_r,
    faultIrq_r,
    simulMode_r,
    modeLocked_r,
    prechg_r,
    2'b00
  };
  // A new fault wins over a clear in the same cycle
  wire [7:0] faultLatch_nxt = (faultLatch_r & {8{~clrCmd}}) | faultS;
  wire [7:0] faultUnmasked = faultLatch_nxt & {irqFilterHigh_r, irqFilterLow_r};

  always @(posedge clk_sys) begin
    if (coreClr) begin
      deadtime_r <= `TPGC_DT_RESET;
      irqFilterLow_r <= `TPGC_FILT_RESET;
      irqFilterHigh_r <= `TPGC_FILT_RESET;
      simulMode_r <= 1'b0;
      modeLocked_r <= 1'b0;
      faultLatch_r <= 8'h00;
      faultIrq_r <= 1'b0;
      rxShift_r <= 16'h0000;
      txShift_r <= 16'h0000;
      bitCnt_r <= 5'h00;
      serialOut_r <= 1'b0;
      serialOutEn_r <= 1'b0;
    end else if (clkEn) begin
      // Serial port keeps working whatever the enables do
      serialOutEn_r <= ~csS_n;
      if (csFall) begin
        bitCnt_r <= 5'h00;
        txShift_r <= statusWord;
      end else if (!csS_n) begin
        if (sclkFall) begin
          rxShift_r <= {rxShift_r[14:0], siS};
          // Count saturates so an over-long frame is never taken as 16 bits
          if (bitCnt_r != 5'h1f) begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
        if (sclkRise) begin
          serialOut_r <= txShift_r[15];
          txShift_r <= {txShift_r[14:0], 1'b0};
        end
      end
      if (frameDone) begin
        if (opcode == `TPGC_OP_DEADTIME) begin
          deadtime_r <= (opData > `TPGC_DT_MAX_STEPS) ? `TPGC_DT_MAX_STEPS : opData;
        end else if (opcode == `TPGC_OP_FILT_LOW) begin
          irqFilterLow_r <= opData[3:0];
        end else if (opcode == `TPGC_OP_FILT_HIGH) begin
          irqFilterHigh_r <= opData[3:0];
        end else if (opcode == `TPGC_OP_MODE) begin
          // Mode is taken once per reset; later mode frames are dropped
          if (!modeLocked_r) begin
            simulMode_r <= opData[0];
            modeLocked_r <= 1'b1;
          end
        end
      end
      faultLatch_r <= faultLatch_nxt;
      faultIrq_r <= |faultUnmasked;
    end
  end

  // ==========================================================
  // Per-phase deadtime and precharge control
  integer i;

  always @(posedge clk_sys) begin
    if (coreClr) begin
      hiDrv_r <= 3'b000;
      loDrv_r <= 3'b000;
      prechg_r <= 3'b000;
      tgt_r <= 6'h00;
      tmr_r <= 33'h000000000;
    end else if (clkEn) begin
      for (i = 0; i < 3; i = i + 1) begin
        // Synced enables clear precharge; the pins themselves gate the outputs below
        if (!enBothS) begin
          hiDrv_r[i] <= 1'b0;
          loDrv_r[i] <= 1'b0;
          prechg_r[i] <= 1'b0;
          tgt_r[i*2 +: 2] <= TGT_NONE;
        end else if (simulMode_r) begin
          // Blanking overridden: drivers follow their commands, high side only once precharged
          hiDrv_r[i] <= hiReq[i] & prechg_r[i];
          loDrv_r[i] <= loReq[i];
          tgt_r[i*2 +: 2] <= TGT_NONE;
          if (loDrv_r[i]) begin
            prechg_r[i] <= 1'b1;
          end
        end else begin
          // Each leading edge restarts the timer, so deadtime counts from the partner's turn-off
          if (loRise[i]) begin
            hiDrv_r[i] <= 1'b0;
            tgt_r[i*2 +: 2] <= TGT_LOW;
            tmr_r[i*11 +: 11] <= dtCycles(deadtime_r);
          end else if (hiRise[i]) begin
            loDrv_r[i] <= 1'b0;
            tgt_r[i*2 +: 2] <= TGT_HIGH;
            tmr_r[i*11 +: 11] <= dtCycles(deadtime_r);
          end else if (tgt_r[i*2 +: 2] != TGT_NONE) begin
            if (tmr_r[i*11 +: 11] == 11'h000) begin
              if (tgt_r[i*2 +: 2] == TGT_LOW) begin
                loDrv_r[i] <= loReq[i];
              end else begin
                hiDrv_r[i] <= hiReq[i] & prechg_r[i];
              end
              tgt_r[i*2 +: 2] <= TGT_NONE;
            end else begin
              tmr_r[i*11 +: 11] <= tmr_r[i*11 +: 11] - 11'h001;
            end
          end
          // Released command turns its driver off at once
          if (!hiReq[i]) begin
            hiDrv_r[i] <= 1'b0;
          end
          if (!loReq[i]) begin
            loDrv_r[i] <= 1'b0;
          end
          if (loDrv_r[i]) begin
            prechg_r[i] <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Power state and comparator outputs
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      gatePullDown_r <= 1'b1;
      driverTristate_r <= 1'b1;
      regulatorEn_r <= 1'b0;
      phaseALevel_r <= 1'b0;
      phaseBLevel_r <= 1'b0;
      phaseCLevel_r <= 1'b0;
      overcurrentFlag_r <= 1'b0;
    end else if (clkEn) begin
      gatePullDown_r <= ~chipRstS_n;
      driverTristate_r <= ~pwrGoodS;
      regulatorEn_r <= chipRstS_n;
      phaseALevel_r <= cmpS[0];
      phaseBLevel_r <= cmpS[1];
      phaseCLevel_r <= cmpS[2];
      overcurrentFlag_r <= ocS;
    end
  end

  // ==========================================================
  // Asynchronous enable gating of the gate drives
  wire enBothPin = driveEnableFirst & driveEnableSecond;

  assign highGateA = hiDrv_r[0] & enBothPin;
  assign highGateB = hiDrv_r[1] & enBothPin;
  assign highGateC = hiDrv_r[2] & enBothPin;
  assign lowGateA = loDrv_r[0] & enBothPin;
  assign lowGateB = loDrv_r[1] & enBothPin;
  assign lowGateC = loDrv_r[2] & enBothPin;

endmodule

`default_nettype wire

// file: testbench/tpgc_gate_ctrl_sva.sv
// Purpose: Assertions on the gate control outputs
// Assumes: clkEn dropped only while the serial port is idle
// Notes: Bound into tpgc_gate_ctrl
`timescale 1ns/1ps
`default_nettype none
module tpgc_gate_ctrl_sva (
  input wire clk_sys,
  input wire reset_n,
  input wire chipReset_n,
  input wire powerGood,
  input wire driveEnableFirst,
  input wire driveEnableSecond,
  input wire lowCmdA,
  input wire chipSelect_n,
  input wire highGateA,
  input wire highGateB,
  input wire highGateC,
  input wire lowGateA,
  input wire lowGateB,
  input wire lowGateC,
  input wire gatePullDown_r,
  input wire driverTristate_r,
  input wire regulatorEn_r,
  input wire faultIrq_r,
  input wire serialOutEn_r
);
  wire gatesOff = !(highGateA | highGateB | highGateC | lowGateA | lowGateB | lowGateC);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Sequences
  sequence sRstLow; !chipReset_n [*5]; endsequence
  sequence sCsIdle; chipSelect_n [*5]; endsequence
  sequence sIrqQuiet; chipSelect_n [*8] ##0 (faultIrq_r && chipReset_n && powerGood); endsequence
  // ==========================================================
  // Checks
  a_gates_need_enables: assert property (!(driveEnableFirst && driveEnableSecond) |-> gatesOff)
    else $error("gate on while an enable is low");
  a_no_shoot_through: assert property (!(highGateA & lowGateA | highGateB & lowGateB | highGateC & lowGateC))
    else $error("both drivers of a phase on");
  a_low_kills_high: assert property ($rose(lowCmdA) |-> ##[1:5] !highGateA)
    else $error("high side not released by low command");
  a_rst_gates_off: assert property (!chipReset_n [*6] |-> gatesOff)
    else $error("gates on during chip reset");
  a_rst_low_power: assert property (sRstLow |-> gatePullDown_r && !regulatorEn_r)
    else $error("no low power state in chip reset");
  a_no_supply_off: assert property (!powerGood [*5] |-> driverTristate_r && !serialOutEn_r && gatesOff)
    else $error("outputs active without supply");
  a_so_idle_high: assert property (sCsIdle |-> !serialOutEn_r)
    else $error("serial out driven while deselected");
  a_irq_held: assert property (sIrqQuiet |=> faultIrq_r)
    else $error("interrupt dropped without clear");
endmodule
bind tpgc_gate_ctrl tpgc_gate_ctrl_sva chk (.clk_sys(clk_sys), .reset_n(reset_n), .chipReset_n(chipReset_n),
  .powerGood(powerGood), .driveEnableFirst(driveEnableFirst), .driveEnableSecond(driveEnableSecond),
  .lowCmdA(lowCmdA), .chipSelect_n(chipSelect_n), .highGateA(highGateA), .highGateB(highGateB),
  .highGateC(highGateC), .lowGateA(lowGateA), .lowGateB(lowGateB), .lowGateC(lowGateC),
  .gatePullDown_r(gatePullDown_r), .driverTristate_r(driverTristate_r), .regulatorEn_r(regulatorEn_r),
  .faultIrq_r(faultIrq_r), .serialOutEn_r(serialOutEn_r));
`default_nettype wire

// file: testbench/tpgc_gate_ctrl_tb.sv
// Purpose: Self-checking bench of the gate control logic
// Assumes: clkEn dropped only while the serial port is idle
// Notes: Deadtime set to 3 steps to keep waits short
`timescale 1ns/1ps
`default_nettype none
`include "tpgc_defines.vh"
module tpgc_gate_ctrl_tb;
  logic clk_sys = 1'h0;
  logic clkEn = 1'h1;
  logic reset_n = 1'h0;
  logic chipReset_n = 1'h1;
  logic powerGood = 1'h1;
  logic driveEnableFirst = 1'h0;
  logic driveEnableSecond = 1'h0;
  logic highCmdA_n = 1'h1, highCmdB_n = 1'h1, highCmdC_n = 1'h1;
  logic lowCmdA = 1'h0, lowCmdB = 1'h0, lowCmdC = 1'h0;
  logic phaseACmp = 1'h0, phaseBCmp = 1'h0, phaseCCmp = 1'h0, overcurrentCmp = 1'h0;
  logic [7:0] faultSource = 8'h00;
  logic [15:0] rx;
  int failures = 0;
  int cmpCount = 0;
  wire serialClk, chipSelect_n, serialIn, serialOut_r, serialOutEn_r;
  wire highGateA, highGateB, highGateC, lowGateA, lowGateB, lowGateC;
  wire gatePullDown_r, driverTristate_r, regulatorEn_r, faultIrq_r;
  wire phaseALevel_r, phaseBLevel_r, phaseCLevel_r, overcurrentFlag_r;
  always #4 clk_sys = ~clk_sys;
  tpgc_gate_ctrl dut (.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn), .chipReset_n(chipReset_n),
    .powerGood(powerGood), .driveEnableFirst(driveEnableFirst), .driveEnableSecond(driveEnableSecond),
    .highCmdA_n(highCmdA_n), .highCmdB_n(highCmdB_n), .highCmdC_n(highCmdC_n), .lowCmdA(lowCmdA),
    .lowCmdB(lowCmdB), .lowCmdC(lowCmdC), .serialClk(serialClk), .chipSelect_n(chipSelect_n),
    .serialIn(serialIn), .phaseACmp(phaseACmp), .phaseBCmp(phaseBCmp), .phaseCCmp(phaseCCmp),
    .overcurrentCmp(overcurrentCmp), .faultSource(faultSource), .highGateA(highGateA), .highGateB(highGateB),
    .highGateC(highGateC), .lowGateA(lowGateA), .lowGateB(lowGateB), .lowGateC(lowGateC),
    .gatePullDown_r(gatePullDown_r), .driverTristate_r(driverTristate_r), .regulatorEn_r(regulatorEn_r),
    .faultIrq_r(faultIrq_r), .serialOut_r(serialOut_r), .serialOutEn_r(serialOutEn_r),
    .phaseALevel_r(phaseALevel_r), .phaseBLevel_r(phaseBLevel_r), .phaseCLevel_r(phaseCLevel_r),
    .overcurrentFlag_r(overcurrentFlag_r));
  tpgc_host_model host (.clk_sys(clk_sys), .serialClk(serialClk), .chipSelect_n(chipSelect_n),
    .serialIn(serialIn), .serialOut_r(serialOut_r));
  // ==========================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chkVec(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmpCount++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkCyc(input string nm, input int lo, input int hi, input int got);
    cmpCount++;
    if (got < lo || got > hi) begin
      failures++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic tLevels;
    logic [3:0] v;
    for (int k = 0; k < 2; k++) begin
      v = k ? 4'h4 : 4'hb;
      {phaseACmp, phaseBCmp, phaseCCmp, overcurrentCmp} = v;
      tick(6);
      chkVec("levels", {12'h000, v}, {12'h000, phaseALevel_r, phaseBLevel_r, phaseCLevel_r, overcurrentFlag_r});
    end
  endtask
  task automatic tFreeze;
    clkEn = 1'h0;
    phaseACmp = 1'h1;
    tick(6);
    chkVec("frozen", 16'h0000, {15'h0000, phaseALevel_r});
    clkEn = 1'h1;
    tick(6);
    chkVec("thawed", 16'h0001, {15'h0000, phaseALevel_r});
    phaseACmp = 1'h0;
    tick(6);
  endtask
  task automatic tGates;
    int n;
    host.frame({`TPGC_OP_DEADTIME, 4'h0, 8'h03}, rx);
    driveEnableFirst = 1'h1;
    driveEnableSecond = 1'h1;
    tick(4);
    highCmdA_n = 1'h0;
    tick(30);
    chkVec("high blocked", 16'h0000, {15'h0000, highGateA});
    highCmdA_n = 1'h1;
    lowCmdA = 1'h1;
    n = 0;
    while (lowGateA !== 1'h1 && n < 200) begin
      tick(1);
      n++;
    end
    chkCyc("low deadtime", 3 * `TPGC_DT_STEP_CYC, 3 * `TPGC_DT_STEP_CYC + 6, n);
    tick(4);
    lowCmdA = 1'h0;
    tick(4);
    highCmdA_n = 1'h0;
    tick(3 * `TPGC_DT_STEP_CYC + 8);
    chkVec("high on", 16'h0001, {15'h0000, highGateA});
    driveEnableSecond = 1'h0;
    #1;
    chkVec("high gated", 16'h0000, {15'h0000, highGateA});
    tick(3);
    driveEnableSecond = 1'h1;
    highCmdA_n = 1'h1;
    tick(4);
    highCmdA_n = 1'h0;
    tick(40);
    chkVec("high fresh", 16'h0000, {15'h0000, highGateA});
    highCmdA_n = 1'h1;
  endtask
  task automatic tIrq;
    driveEnableFirst = 1'h0;
    faultSource = 8'h01;
    tick(6);
    chkVec("irq set", 16'h0001, {15'h0000, faultIrq_r});
    faultSource = 8'h00;
    tick(20);
    chkVec("irq held", 16'h0001, {15'h0000, faultIrq_r});
    host.frame({`TPGC_OP_CLR_IRQ, 12'h000}, rx);
    chkVec("irq clear", 16'h0000, {15'h0000, faultIrq_r});
    host.frame({`TPGC_OP_FILT_LOW, 12'h000}, rx);
    host.frame({`TPGC_OP_FILT_HIGH, 12'h00e}, rx);
    faultSource = 8'h11;
    tick(6);
    chkVec("irq masked", 16'h0000, {15'h0000, faultIrq_r});
    faultSource = 8'h31;
    tick(6);
    chkVec("irq open", 16'h0001, {15'h0000, faultIrq_r});
    faultSource = 8'h00;
    host.frame({`TPGC_OP_MODE, 4'h0, 8'h00}, rx);
    host.frame({`TPGC_OP_MODE, 4'h0, 8'h01}, rx);
    host.frame({`TPGC_OP_NOP, 12'h000}, rx);
    chkVec("status", {8'h31, 1'h1, 1'h0, 1'h1, 5'h00}, rx);
  endtask
  task automatic tPower;
    driveEnableFirst = 1'h1;
    lowCmdA = 1'h1;
    tick(30);
    chkVec("low on", 16'h0001, {15'h0000, lowGateA});
    lowCmdA = 1'h0;
    tick(4);
    highCmdA_n = 1'h0;
    tick(30);
    chkVec("high again", 16'h0001, {15'h0000, highGateA});
    lowCmdA = 1'h1;
    tick(4);
    chkVec("high cut", 16'h0000, {15'h0000, highGateA});
    tick(26);
    chipReset_n = 1'h0;
    tick(9);
    chkVec("chip reset", 16'h0002, {13'h0000, lowGateA, gatePullDown_r, regulatorEn_r});
    chipReset_n = 1'h1;
    lowCmdA = 1'h0;
    highCmdA_n = 1'h1;
    tick(10);
    powerGood = 1'h0;
    tick(6);
    chkVec("no supply", 16'h0002, {14'h0000, driverTristate_r, serialOutEn_r});
    powerGood = 1'h1;
    tick(10);
  endtask
  initial begin
    tick(3);
    reset_n = 1'h1;
    tick(8);
    tLevels();
    tFreeze();
    tGates();
    tIrq();
    tPower();
    conclude();
  end
  initial begin
    #100000;
    failures++;
    conclude();
  end
endmodule
`default_nettype wire

// file: testbench/tpgc_host_model.sv
// Purpose: Host side of the serial port
// Assumes: Called just after a falling clk_sys edge
// Notes: Link clock period is 10 clk_sys cycles
`timescale 1ns/1ps
`default_nettype none
module tpgc_host_model (
  input wire clk_sys,
  output logic serialClk,
  output logic chipSelect_n,
  output logic serialIn,
  input wire serialOut_r
);
  // Link clock stands low and data falls to its pull-down outside frames
  initial begin
    serialClk = 1'h0;
    chipSelect_n = 1'h1;
    serialIn = 1'h0;
  end
  task automatic waitClk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    chipSelect_n = 1'h0;
    waitClk(5);
    for (int i = 15; i >= 0; i--) begin
      serialClk = 1'h1;
      serialIn = tx[i];
      waitClk(5);
      serialClk = 1'h0;
      rx[i] = serialOut_r;
      waitClk(5);
    end
    chipSelect_n = 1'h1;
    serialIn = 1'h0;
    waitClk(6);
  endtask
endmodule
`default_nettype wire
